// ===== hdl/ldclo_pkg.sv
package ldclo_pkg;
	localparam int ACC_W      = 24;
	localparam int DIGITS     = 6;
	localparam int SEG_W      = 8;
	localparam int DISP_W     = 24;
	// opcode selector
	typedef enum logic [2:0] {
		LDCLO_OP_NONE,
		LDCLO_OP_NOP,
		LDCLO_OP_NOR,
		LDCLO_OP_D2S,
		LDCLO_OP_D2S_ACC,
		LDCLO_OP_REFRESH
	} ldclo_op_t;
	// accumulator indices
	localparam logic [1:0] ACC_X = 2'h0;
	localparam logic [1:0] ACC_Y = 2'h1;
	localparam logic [1:0] ACC_Z = 2'h2;
	localparam logic [1:0] ACC_R = 2'h3;
	// cycle counts
	localparam logic [2:0] CYC_NOP     = 3'h1;
	localparam logic [2:0] CYC_NOR_ACC = 3'h3;
	localparam logic [2:0] CYC_NOR_IMM = 3'h6;
	localparam logic [2:0] CYC_D2S     = 3'h3;
	localparam logic [2:0] CYC_REFRESH = 3'h3;
	// byte lengths
	localparam logic [2:0] LEN_NOP     = 3'h1;
	localparam logic [2:0] LEN_NOR_ACC = 3'h2;
	localparam logic [2:0] LEN_NOR_IMM = 3'h5;
	localparam logic [2:0] LEN_D2S     = 3'h3;
	localparam logic [2:0] LEN_REFRESH = 3'h2;
	// decimal point position limits
	localparam logic [2:0] DP_MIN = 3'h1;
	localparam logic [2:0] DP_MAX = 3'h6;
	// segment register fields (reg61 = digits 0..2, reg62 = digits 3..5)
	localparam int SEG_DP_BIT = 7;
	localparam logic [SEG_W-1:0] SEG_BLANK = 8'h00;
endpackage

// ===== hdl/ldclo_seg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ldclo_seg_if;
	logic [23:0] value;
	logic [2:0]  dp_pos;
	logic [47:0] segs;
	modport conv (input value, input dp_pos, output segs);
	modport user (output value, output dp_pos, input segs);
endinterface
`default_nettype wire

// ===== hdl/ldclo_seg_conv.sv
`timescale 1ns/1ps
`default_nettype none
module ldclo_seg_conv (
	// conversion port
	ldclo_seg_if.conv cv
);
	function automatic logic [6:0] ldclo_enc(input logic [3:0] d);
		case (d)
			4'h0: ldclo_enc = 7'h3F;
			4'h1: ldclo_enc = 7'h06;
			4'h2: ldclo_enc = 7'h5B;
			4'h3: ldclo_enc = 7'h4F;
			4'h4: ldclo_enc = 7'h66;
			4'h5: ldclo_enc = 7'h6D;
			4'h6: ldclo_enc = 7'h7D;
			4'h7: ldclo_enc = 7'h07;
			4'h8: ldclo_enc = 7'h7F;
			4'h9: ldclo_enc = 7'h6F;
			default: ldclo_enc = 7'h40;
		endcase
	endfunction

	// digit i blanked when it and all higher digits are zero and it sits left of the point
	logic [ldclo_pkg::DIGITS:0] lead_zero;
	assign lead_zero[ldclo_pkg::DIGITS] = 1'b1;
	genvar i;
	generate
		for (i = 0; i < ldclo_pkg::DIGITS; i++) begin : g_dig
			logic [3:0] d;
			logic       is_dp;
			logic       blank;
			assign d     = cv.value[4*i +: 4];
			assign is_dp = (cv.dp_pos == 3'(i + 1));
			assign lead_zero[i] = lead_zero[i+1] && (d == 4'h0) && (3'(i + 1) > cv.dp_pos);
			assign blank = lead_zero[i];
			assign cv.segs[ldclo_pkg::SEG_W*i +: ldclo_pkg::SEG_W] =
				blank ? ldclo_pkg::SEG_BLANK : {is_dp, ldclo_enc(d)};
		end
	endgenerate
endmodule
`default_nettype wire

// ===== hdl/ldclo_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - digit conversion turns six BCD digits of source accumulator into segment patterns
// - decimal point placed at digit position given by operand 1 to 6
// - leading zeros left of the decimal point are blanked
// - conversion result written straight into segment registers 61 and 62
// - refresh opcode copies registers 61 to 63 to the display driver
// - nop is one byte, one cycle, changes nothing
// - nor stores bitwise nor into first operand and updates sign and zero flags
// - nor destination is x,y,z,r; source is accumulator or immediate
// - nor with two accumulators is 2 bytes, 3 cycles
// - nor with immediate is 5 bytes, 6 cycles
module ldclo_core (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// command
	input  wire logic        cmd_valid,
	input  wire logic [2:0]  cmd_op,
	input  wire logic [1:0]  cmd_dst,
	input  wire logic [1:0]  cmd_src,
	input  wire logic        cmd_imm_sel,
	input  wire logic [23:0] cmd_imm,
	input  wire logic [2:0]  cmd_dp_pos,
	input  wire logic [23:0] reg63_wdata,
	input  wire logic        reg63_we,
	// status
	output logic             busy,
	output logic             done,
	output logic [2:0]       instr_len,
	// accumulators and flags
	output logic [23:0]      acc_x,
	output logic [23:0]      acc_y,
	output logic [23:0]      acc_z,
	output logic [23:0]      acc_r,
	output logic             flag_sign,
	output logic             flag_zero,
	// segment registers and display
	output logic [23:0]      seg61,
	output logic [23:0]      seg62,
	output logic [23:0]      seg63,
	output logic [71:0]      disp_data,
	output logic             disp_load
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} ldclo_state_t;

	ldclo_state_t        st_r;
	ldclo_pkg::ldclo_op_t op_r;
	logic [2:0]          cnt_r;
	logic [1:0]          dst_r;
	logic [23:0]         opb_r;
	logic [2:0]          dp_r;
	logic [23:0]         acc_a  [4];
	logic [23:0]         nor_res;
	logic [23:0]         src_val;
	logic [23:0]         conv_src;
	logic [2:0]          cyc_need;
	logic [2:0]          len_need;
	logic                finish;

	ldclo_seg_if seg_bus ();
	ldclo_seg_conv u_conv (.cv(seg_bus.conv));

	assign acc_a[0] = acc_x;
	assign acc_a[1] = acc_y;
	assign acc_a[2] = acc_z;
	assign acc_a[3] = acc_r;
	assign src_val  = cmd_imm_sel ? cmd_imm : acc_a[cmd_src];
	// plain conversion always uses x; variant uses x or y
	assign conv_src = (cmd_op == ldclo_pkg::LDCLO_OP_D2S_ACC && cmd_src == ldclo_pkg::ACC_Y)
		? acc_y : acc_x;
	assign nor_res  = ~(acc_a[dst_r] | opb_r);
	assign seg_bus.value  = opb_r;
	assign seg_bus.dp_pos = dp_r;
	assign finish = (st_r == ST_RUN) && (cnt_r == 3'h1);

	// ----------------------------------------
	// cycle and length per opcode
	// ----------------------------------------
	always_comb begin
		cyc_need = ldclo_pkg::CYC_NOP;
		len_need = ldclo_pkg::LEN_NOP;
		case (ldclo_pkg::ldclo_op_t'(cmd_op))
			ldclo_pkg::LDCLO_OP_NOP: begin
				cyc_need = ldclo_pkg::CYC_NOP;
				len_need = ldclo_pkg::LEN_NOP;
			end
			ldclo_pkg::LDCLO_OP_NOR: begin
				cyc_need = cmd_imm_sel ? ldclo_pkg::CYC_NOR_IMM : ldclo_pkg::CYC_NOR_ACC;
				len_need = cmd_imm_sel ? ldclo_pkg::LEN_NOR_IMM : ldclo_pkg::LEN_NOR_ACC;
			end
			ldclo_pkg::LDCLO_OP_D2S, ldclo_pkg::LDCLO_OP_D2S_ACC: begin
				cyc_need = ldclo_pkg::CYC_D2S;
				len_need = ldclo_pkg::LEN_D2S;
			end
			ldclo_pkg::LDCLO_OP_REFRESH: begin
				cyc_need = ldclo_pkg::CYC_REFRESH;
				len_need = ldclo_pkg::LEN_REFRESH;
			end
			default: begin
				cyc_need = ldclo_pkg::CYC_NOP;
				len_need = ldclo_pkg::LEN_NOP;
			end
		endcase
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_r      <= ST_IDLE;
			op_r      <= ldclo_pkg::LDCLO_OP_NONE;
			cnt_r     <= 3'h0;
			dst_r     <= 2'h0;
			opb_r     <= 24'h000000;
			dp_r      <= 3'h1;
			busy      <= 1'b0;
			done      <= 1'b0;
			instr_len <= 3'h0;
		end else begin
			done <= 1'b0;
			case (st_r)
				ST_IDLE: begin
					if (cmd_valid) begin
						op_r      <= ldclo_pkg::ldclo_op_t'(cmd_op);
						cnt_r     <= cyc_need;
						dst_r     <= cmd_dst;
						dp_r      <= (cmd_dp_pos < ldclo_pkg::DP_MIN) ? ldclo_pkg::DP_MIN :
							(cmd_dp_pos > ldclo_pkg::DP_MAX) ? ldclo_pkg::DP_MAX : cmd_dp_pos;
						opb_r     <= (cmd_op == ldclo_pkg::LDCLO_OP_NOR) ? src_val : conv_src;
						instr_len <= len_need;
						busy      <= 1'b1;
						st_r      <= ST_RUN;
					end
				end
				ST_RUN: begin
					cnt_r <= cnt_r - 3'h1;
					if (finish) begin
						busy <= 1'b0;
						done <= 1'b1;
						st_r <= ST_IDLE;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// accumulators and flags
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			acc_x     <= 24'h000000;
			acc_y     <= 24'h000000;
			acc_z     <= 24'h000000;
			acc_r     <= 24'h000000;
			flag_sign <= 1'b0;
			flag_zero <= 1'b0;
		end else if (finish && op_r == ldclo_pkg::LDCLO_OP_NOR) begin
			case (dst_r)
				ldclo_pkg::ACC_X: acc_x <= nor_res;
				ldclo_pkg::ACC_Y: acc_y <= nor_res;
				ldclo_pkg::ACC_Z: acc_z <= nor_res;
				default:          acc_r <= nor_res;
			endcase
			flag_sign <= nor_res[ldclo_pkg::ACC_W-1];
			flag_zero <= (nor_res == 24'h000000);
		end
	end

	// ----------------------------------------
	// segment registers and display load
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			seg61     <= 24'h000000;
			seg62     <= 24'h000000;
			seg63     <= 24'h000000;
			disp_data <= 72'h0;
			disp_load <= 1'b0;
		end else begin
			disp_load <= 1'b0;
			if (reg63_we) begin
				seg63 <= reg63_wdata;
			end
			if (finish && (op_r == ldclo_pkg::LDCLO_OP_D2S || op_r == ldclo_pkg::LDCLO_OP_D2S_ACC)) begin
				seg61 <= seg_bus.segs[23:0];
				seg62 <= seg_bus.segs[47:24];
			end
			if (finish && op_r == ldclo_pkg::LDCLO_OP_REFRESH) begin
				disp_data <= {seg63, seg62, seg61};
				disp_load <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_nop_one_cycle: assert property (@(posedge mclk) disable iff (!resetn)
		(st_r == ST_IDLE && cmd_valid && cmd_op == ldclo_pkg::LDCLO_OP_NOP)
		|=> ##1 (done && $stable(acc_x) && $stable(acc_y) && $stable(flag_zero)))
		else $error("nop did not finish in one cycle");
	chk_nor_acc_time: assert property (@(posedge mclk) disable iff (!resetn)
		(st_r == ST_IDLE && cmd_valid && cmd_op == ldclo_pkg::LDCLO_OP_NOR && !cmd_imm_sel)
		|=> !done [*3] ##1 done)
		else $error("nor with accumulator not 3 cycles");
	chk_nor_imm_time: assert property (@(posedge mclk) disable iff (!resetn)
		(st_r == ST_IDLE && cmd_valid && cmd_op == ldclo_pkg::LDCLO_OP_NOR && cmd_imm_sel)
		|=> !done [*6] ##1 done)
		else $error("nor with immediate not 6 cycles");
	chk_nor_len: assert property (@(posedge mclk) disable iff (!resetn)
		(st_r == ST_IDLE && cmd_valid && cmd_op == ldclo_pkg::LDCLO_OP_NOR)
		|=> instr_len == ($past(cmd_imm_sel) ? ldclo_pkg::LEN_NOR_IMM : ldclo_pkg::LEN_NOR_ACC))
		else $error("nor length wrong");
	chk_nor_zero_flag: assert property (@(posedge mclk) disable iff (!resetn)
		(finish && op_r == ldclo_pkg::LDCLO_OP_NOR)
		|=> flag_zero == ($past(nor_res) == 24'h000000) && flag_sign == $past(nor_res[23]))
		else $error("nor flags wrong");
	chk_nor_value: assert property (@(posedge mclk) disable iff (!resetn)
		(finish && op_r == ldclo_pkg::LDCLO_OP_NOR && dst_r == ldclo_pkg::ACC_Z)
		|=> acc_z == ~($past(acc_z) | $past(opb_r)))
		else $error("nor result wrong");
	chk_seg_write: assert property (@(posedge mclk) disable iff (!resetn)
		(finish && op_r == ldclo_pkg::LDCLO_OP_D2S) |=> {seg62, seg61} == $past(seg_bus.segs))
		else $error("segment registers not written");
	chk_refresh_copy: assert property (@(posedge mclk) disable iff (!resetn)
		(finish && op_r == ldclo_pkg::LDCLO_OP_REFRESH && !reg63_we) |=> disp_load && disp_data == {seg63, seg62, seg61})
		else $error("display refresh wrong");
	chk_lead_blank: assert property (@(posedge mclk) disable iff (!resetn)
		(st_r == ST_RUN && opb_r[23:20] == 4'h0 && dp_r < 3'h6) |-> seg_bus.segs[47:40] == 8'h00)
		else $error("leading zero shown");
endmodule
`default_nettype wire

// ===== tb/ldclo_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module ldclo_core_test;
	logic        mclk;
	logic        resetn;
	logic        cmd_valid;
	logic [2:0]  cmd_op;
	logic [1:0]  cmd_dst;
	logic [1:0]  cmd_src;
	logic        cmd_imm_sel;
	logic [23:0] cmd_imm;
	logic [2:0]  cmd_dp_pos;
	logic [23:0] reg63_wdata;
	logic        reg63_we;
	logic        busy;
	logic        done;
	logic [2:0]  instr_len;
	logic [23:0] acc_x;
	logic [23:0] acc_y;
	logic [23:0] acc_z;
	logic [23:0] acc_r;
	logic        flag_sign;
	logic        flag_zero;
	logic [23:0] seg61;
	logic [23:0] seg62;
	logic [23:0] seg63;
	logic [71:0] disp_data;
	logic        disp_load;
	int          bad_count;
	int          checks;
	int          cycles;
	int          cyc;

	ldclo_core dut_u (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_dst(cmd_dst),
		.cmd_src(cmd_src), .cmd_imm_sel(cmd_imm_sel), .cmd_imm(cmd_imm), .cmd_dp_pos(cmd_dp_pos),
		.reg63_wdata(reg63_wdata), .reg63_we(reg63_we), .busy(busy), .done(done), .instr_len(instr_len),
		.acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .acc_r(acc_r), .flag_sign(flag_sign),
		.flag_zero(flag_zero), .seg61(seg61), .seg62(seg62), .seg63(seg63), .disp_data(disp_data),
		.disp_load(disp_load));

	always #20 mclk = ~mclk;

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic results();
		$display("errors %0d, comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cmp_val(input logic [97:0] got, input logic [97:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_cnt(input int got, input int exp);
		checks++;
		if (got != exp) begin
			bad_count++;
			$display("mismatch at %0t: took %0d cycles, expected %0d", $time, got, exp);
		end
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			$display("mismatch at %0t: run did not finish", $time);
			results();
		end
	end

	// ----------------------------------------
	// opcode driver and reference
	// ----------------------------------------
	task automatic run(input ldclo_pkg::ldclo_op_t op, input logic [1:0] dst, input logic [1:0] src,
			input logic isel, input logic [23:0] imm, input logic [2:0] dp, input int ncyc, input logic [2:0] len);
		@(negedge mclk);
		cmd_op = op;
		cmd_dst = dst;
		cmd_src = src;
		cmd_imm_sel = isel;
		cmd_imm = imm;
		cmd_dp_pos = dp;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		cmp_val(busy, 98'h1, "busy");
		cyc = 0;
		while (done !== 1'b1 && cyc < 20) begin
			@(negedge mclk);
			cyc++;
		end
		cmp_cnt(cyc, ncyc);
		cmp_val(instr_len, len, "length");
		cmp_val(busy, 98'h0, "idle");
	endtask

	function automatic logic [23:0] acc(input logic [1:0] d);
		return d == 2'h0 ? acc_x : d == 2'h1 ? acc_y : d == 2'h2 ? acc_z : acc_r;
	endfunction

	// nor with all-ones clears, then nor with inverse loads
	task automatic load(input logic [1:0] d, input logic [23:0] v);
		run(ldclo_pkg::LDCLO_OP_NOR, d, 2'h0, 1'b1, 24'hFFFFFF, 3'h1, 6, 3'h5);
		run(ldclo_pkg::LDCLO_OP_NOR, d, 2'h0, 1'b1, ~v, 3'h1, 6, 3'h5);
	endtask

	function automatic logic [47:0] conv_exp(input logic [23:0] v, input logic [2:0] dp);
		logic [6:0]  tbl [10];
		logic [47:0] r;
		logic        lead;
		logic [3:0]  n;
		tbl = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
		lead = 1'b1;
		for (int i = 6; i >= 1; i--) begin
			n = v[4*i-4 +: 4];
			lead = lead && n == 4'h0 && i > dp;
			r[8*i-8 +: 8] = lead ? 8'h00 : {i == dp, n > 4'h9 ? 7'h40 : tbl[n]};
		end
		return r;
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_nor_acc();
		run(ldclo_pkg::LDCLO_OP_NOR, 2'h0, 2'h1, 1'b0, 24'h000000, 3'h1, 3, 3'h2);
		cmp_val({acc_x, flag_sign, flag_zero}, {24'hFFFFFF, 2'b10}, "nor x");
		run(ldclo_pkg::LDCLO_OP_NOR, 2'h1, 2'h0, 1'b0, 24'h000000, 3'h1, 3, 3'h2);
		cmp_val({acc_y, flag_sign, flag_zero}, {24'h000000, 2'b01}, "nor y");
	endtask

	task automatic t_nor_imm();
		logic [23:0] v;
		for (int d = 0; d < 4; d++) begin
			v = 24'h5A0F3C ^ {22'h0, d[1:0]};
			load(d[1:0], v);
			cmp_val(acc(d[1:0]), v, "load");
			run(ldclo_pkg::LDCLO_OP_NOR, d[1:0], 2'h0, 1'b1, 24'h0F0F0F, 3'h1, 6, 3'h5);
			cmp_val({acc(d[1:0]), flag_sign, flag_zero}, {~(v | 24'h0F0F0F), 2'b10}, "nor imm");
		end
	endtask

	task automatic t_nop();
		logic [97:0] snap;
		snap = {acc_x, acc_y, acc_z, acc_r, flag_sign, flag_zero};
		run(ldclo_pkg::LDCLO_OP_NOP, 2'h2, 2'h3, 1'b1, 24'h123456, 3'h2, 1, 3'h1);
		cmp_val({acc_x, acc_y, acc_z, acc_r, flag_sign, flag_zero}, snap, "nop state");
		run(ldclo_pkg::LDCLO_OP_NONE, 2'h1, 2'h2, 1'b0, 24'h654321, 3'h5, 1, 3'h1);
		cmp_val({acc_x, acc_y, acc_z, acc_r, flag_sign, flag_zero}, snap, "idle op state");
	endtask

	task automatic t_conv();
		logic [23:0] vals [5];
		logic [2:0]  dps [5];
		vals = '{24'h001230, 24'h000005, 24'h000000, 24'h90A004, 24'h000000};
		dps = '{3'h1, 3'h3, 3'h6, 3'h2, 3'h1};
		for (int k = 0; k < 5; k++) begin
			load(2'h0, vals[k]);
			load(2'h1, ~vals[k]);
			run(ldclo_pkg::LDCLO_OP_D2S, 2'h0, 2'h1, 1'b0, 24'h0, dps[k], 3, 3'h3);
			cmp_val({seg62, seg61}, conv_exp(vals[k], dps[k]), "convert");
			run(ldclo_pkg::LDCLO_OP_D2S_ACC, 2'h0, 2'h1, 1'b0, 24'h0, dps[k], 3, 3'h3);
			cmp_val({seg62, seg61}, conv_exp(~vals[k], dps[k]), "convert y");
			load(2'h1, 24'h000000);
			run(ldclo_pkg::LDCLO_OP_D2S_ACC, 2'h0, 2'h0, 1'b0, 24'h0, dps[k], 3, 3'h3);
			cmp_val({seg62, seg61}, conv_exp(vals[k], dps[k]), "convert x");
		end
	endtask

	task automatic t_refresh();
		@(negedge mclk);
		reg63_wdata = 24'hC35A81;
		reg63_we = 1'b1;
		@(negedge mclk);
		reg63_we = 1'b0;
		load(2'h0, 24'h004711);
		run(ldclo_pkg::LDCLO_OP_D2S, 2'h0, 2'h0, 1'b0, 24'h0, 3'h4, 3, 3'h3);
		run(ldclo_pkg::LDCLO_OP_REFRESH, 2'h0, 2'h0, 1'b0, 24'h0, 3'h1, 3, 3'h2);
		cmp_val({disp_load, disp_data}, {1'b1, 24'hC35A81, conv_exp(24'h004711, 3'h4)}, "refresh");
		@(negedge mclk);
		cmp_val(disp_load, 72'h0, "load pulse");
	endtask

	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 3'h0;
		cmd_dst = 2'h0;
		cmd_src = 2'h0;
		cmd_imm_sel = 1'b0;
		cmd_imm = 24'h0;
		cmd_dp_pos = 3'h1;
		reg63_wdata = 24'h0;
		reg63_we = 1'b0;
		bad_count = 0;
		checks = 0;
		cycles = 0;
		repeat (8) @(negedge mclk);
		resetn = 1'b1;
		cmp_val({acc_x, acc_y, busy, done}, 72'h0, "reset");
		t_nor_acc();
		t_nor_imm();
		t_nop();
		t_conv();
		t_refresh();
		results();
	end
endmodule
`default_nettype wire
